/* include/ppp_pkg.sv */
// Purpose: Shared types and constants for the PROM programming port host.
// Assumes: 40 MHz MCLK_I; one device on the programming pins.
// Notes:   Pulse, access and settle counts derive from the times below; VERIFY_CYC adds SYNC_CYC plus one fixed cycle.
//
// Functional notes
// R1 - Hold device reset low while programming supply sits at 5 V or 12.5 V.
// R2 - Program only addresses 0000h to 5fffh; final address is given explicitly.
// R3 - Select low and read strobe low at read supplies outputs the addressed byte.
// R4 - Read strobe high puts the device data lines in high impedance.
// R5 - On a shared bus only the chosen device gets its read strobe low.
// R6 - Select high means standby; device data lines float whatever the strobe.
// R7 - Select high, program strobe high, read strobe low latches page bytes.
// R8 - Latch, write, verify use 12.5 V and 6.5 V; read uses 5 V on both.
// R9 - Page write: select and read strobe high, 0.1 ms low pulse, retry up to 10.
// R10 - Byte write: select low, read strobe high, 0.1 ms low program pulse.
// R11 - Select low, program strobe high, read strobe low gives verify output.
// R12 - A device whose program strobe stays high is never written.
// R13 - Device drives data lines only in read and verify modes.
package ppp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int PULSE_NS     = 100000;  // Program pulse, 0.1 ms
  localparam int ACCESS_NS    = 200;     // Data valid after strobes
  localparam int SETTLE_NS    = 2000;    // Supply settling
  localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC     = 2;
  localparam int VERIFY_CYC   = ACCESS_CYC + SYNC_CYC + 1;

  // ---------------------------------------------------------------
  // Memory layout
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 15;
  localparam logic [14:0] LAST_ADDR  = 15'h5fff;
  localparam int          PAGE_BYTES = 4;
  localparam int          MAX_TRIES  = 10;

  typedef enum logic [1:0] {
    PPP_OP_READ = 2'h0,
    PPP_OP_BYTE = 2'h1,
    PPP_OP_PAGE = 2'h2
  } ppp_op_e;

  typedef struct packed {
    ppp_op_e     op;
    logic [14:0] addr;
    logic [31:0] data;   // Byte n of a page in bits 8n+7:8n
  } ppp_cmd_s;

  typedef enum logic [2:0] {
    PPP_IDLE   = 3'h0,
    PPP_SETUP  = 3'h1,
    PPP_LATCH  = 3'h2,
    PPP_PULSE  = 3'h3,
    PPP_VERIFY = 3'h4,
    PPP_DONE   = 3'h5
  } ppp_state_e;

endpackage : ppp_pkg

/* hw/ppp_host.sv */
// Purpose: Drives the PROM programming pins for read, byte and page writes.
// Assumes: Device supplies switch from VPP_HI_O / VDD_HI_O level selects.
// Notes:   One command at a time; verify retries are automatic.
`timescale 1ns/1ps
`default_nettype none

module ppp_host
  import ppp_pkg::*;
#(
  parameter int TRIES = MAX_TRIES
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CMD_VALID_I,
  input  wire ppp_cmd_s    CMD_I,
  output logic             CMD_READY_O,
  output logic             DONE_O,
  output logic             FAIL_O,
  output logic [7:0]       RDATA_O,
  output logic             PROM_RST_B_O,
  output logic             VPP_HI_O,
  output logic             VDD_HI_O,
  output logic             CE_B_O,
  output logic             OE_B_O,
  output logic             PROGRAM_STROBE_N_O,
  output logic [14:0]      PROG_ADDR_LINES_O,
  input  wire logic [7:0]  PROG_DATA_LINES_I,
  output logic [7:0]       PROG_DATA_LINES_O,
  output logic             PROG_DATA_LINES_OE_O
);

  if (TRIES < 1 || TRIES > 15) begin : g_bad_tries
    $error("TRIES must lie in 1..15");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ppp_state_e  state_q, state_d;
  ppp_cmd_s    cmd_q, cmd_d;
  logic [1:0]  idx_q, idx_d;
  logic [3:0]  tries_q, tries_d;
  logic [15:0] cnt_q;
  logic        fail_d;
  logic [7:0]  sync1_q, sync2_q;
  logic [7:0]  expect_b;
  logic        bad_addr;
  logic        accept;

  assign accept   = (state_q == PPP_IDLE) && CMD_VALID_I;
  assign expect_b = cmd_q.data[{idx_q, 3'h0} +: 8];

  // Reject addresses past the last cell and unaligned or straddling pages
  always_comb begin
    bad_addr = CMD_I.addr > LAST_ADDR;                             // R2
    if (CMD_I.op == PPP_OP_PAGE) begin
      bad_addr = (CMD_I.addr[1:0] != 2'h0) ||
                 (CMD_I.addr > (LAST_ADDR - 15'h0003));            // R2
    end
    // The fourth op code has no meaning; refuse it like a bad address
    if (!(CMD_I.op inside {PPP_OP_READ, PPP_OP_BYTE, PPP_OP_PAGE})) begin
      bad_addr = 1'b1;
    end
  end

  // Next-state logic; pins are registered from these next values
  always_comb begin
    state_d = state_q;
    cmd_d   = accept ? CMD_I : cmd_q;
    idx_d   = idx_q;
    tries_d = tries_q;
    fail_d  = 1'b0;
    unique case (state_q)
      PPP_IDLE: begin
        if (CMD_VALID_I) begin
          idx_d   = 2'h0;
          tries_d = 4'h0;
          if (bad_addr || CMD_I.op == 2'h3) begin
            state_d = PPP_DONE;
            fail_d  = 1'b1;
          end else begin
            state_d = PPP_SETUP;
          end
        end
      end
      PPP_SETUP: begin
        if (cnt_q == 16'(SETTLE_CYC - 1)) begin
          unique case (cmd_q.op)
            PPP_OP_READ: state_d = PPP_VERIFY;
            PPP_OP_BYTE: begin
              state_d = PPP_PULSE;
              tries_d = 4'h1;
            end
            default:     state_d = PPP_LATCH;
          endcase
        end
      end
      PPP_LATCH: begin
        if (cnt_q == 16'(ACCESS_CYC - 1)) begin
          if (idx_q == 2'(PAGE_BYTES - 1)) begin
            state_d = PPP_PULSE;
            idx_d   = 2'h0;
            tries_d = tries_q + 4'h1;
          end else begin
            idx_d = idx_q + 2'h1;                                  // R7
          end
        end
      end
      PPP_PULSE: begin
        if (cnt_q == 16'(PULSE_CYC - 1)) begin                     // R9
          state_d = PPP_VERIFY;
        end
      end
      PPP_VERIFY: begin
        if (cnt_q == 16'(VERIFY_CYC - 1)) begin
          if (cmd_q.op == PPP_OP_READ) begin
            state_d = PPP_DONE;
          end else if (sync2_q == expect_b) begin
            if (cmd_q.op == PPP_OP_BYTE ||
                idx_q == 2'(PAGE_BYTES - 1)) begin
              state_d = PPP_DONE;
            end else begin
              idx_d = idx_q + 2'h1;
            end
          end else if (tries_q < 4'(TRIES)) begin                  // R9
            idx_d   = 2'h0;
            state_d = (cmd_q.op == PPP_OP_BYTE) ? PPP_PULSE : PPP_LATCH;
            if (cmd_q.op == PPP_OP_BYTE) begin
              tries_d = tries_q + 4'h1;
            end
          end else begin
            state_d = PPP_DONE;
            fail_d  = 1'b1;
          end
        end
      end
      PPP_DONE: state_d = PPP_IDLE;
      default:  state_d = PPP_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= PPP_IDLE;
      cmd_q   <= '0;
      idx_q   <= 2'h0;
      tries_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      idx_q   <= idx_d;
      tries_q <= tries_d;
    end
  end

  // Dwell counter restarts on every step so each byte gets full time
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cnt_q <= 16'h0000;
    end else if (state_d != state_q || idx_d != idx_q) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Data lines come from another chip; two flops before any compare
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= PROG_DATA_LINES_I;
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive, decoded from next state so pins come from flops
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PROM_RST_B_O         <= 1'b0;
      VPP_HI_O             <= 1'b0;
      VDD_HI_O             <= 1'b0;
      CE_B_O               <= 1'b1;
      OE_B_O               <= 1'b1;
      PROGRAM_STROBE_N_O   <= 1'b1;
      PROG_ADDR_LINES_O    <= 15'h0000;
      PROG_DATA_LINES_O    <= 8'h00;
      PROG_DATA_LINES_OE_O <= 1'b0;
    end else begin
      PROM_RST_B_O <= 1'b0;                                        // R1
      // Read stays at 5 V; every write path runs at high supplies
      VPP_HI_O <= (state_d != PPP_IDLE) && (state_d != PPP_DONE) &&
                  (cmd_d.op != PPP_OP_READ);                       // R8
      VDD_HI_O <= (state_d != PPP_IDLE) && (state_d != PPP_DONE) &&
                  (cmd_d.op != PPP_OP_READ);                       // R8
      PROG_ADDR_LINES_O <= cmd_d.addr + {13'h0000, idx_d};         // R2
      PROG_DATA_LINES_O <= cmd_d.data[{idx_d, 3'h0} +: 8];
      CE_B_O               <= 1'b1;
      OE_B_O               <= 1'b1;
      PROGRAM_STROBE_N_O   <= 1'b1;
      PROG_DATA_LINES_OE_O <= 1'b0;
      unique case (state_d)
        PPP_LATCH: begin
          OE_B_O               <= 1'b0;                            // R7
          PROG_DATA_LINES_OE_O <= 1'b1;
        end
        PPP_PULSE: begin
          PROGRAM_STROBE_N_O <= 1'b0;
          if (cmd_d.op == PPP_OP_BYTE) begin
            CE_B_O               <= 1'b0;                          // R10
            PROG_DATA_LINES_OE_O <= 1'b1;
          end
        end
        PPP_VERIFY: begin
          // Released bus so the device can answer without contention
          CE_B_O <= 1'b0;                                          // R5
          OE_B_O <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Command handshake and result
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CMD_READY_O <= 1'b0;
      DONE_O      <= 1'b0;
      FAIL_O      <= 1'b0;
      RDATA_O     <= 8'h00;
    end else begin
      CMD_READY_O <= (state_d == PPP_IDLE);
      DONE_O      <= (state_d == PPP_DONE);
      if (state_d == PPP_DONE && state_q != PPP_DONE) begin
        FAIL_O <= fail_d;
      end
      if (state_q == PPP_VERIFY && state_d == PPP_DONE) begin
        RDATA_O <= sync2_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] low_cnt_q;
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      low_cnt_q <= 16'h0000;
    end else if (!PROGRAM_STROBE_N_O) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end else begin
      low_cnt_q <= 16'h0000;
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_pulse_end;
    $rose(PROGRAM_STROBE_N_O);
  endsequence

  reset_held_a: assert property (PROM_RST_B_O == 1'b0) // R1
    else $error("device reset released");
  addr_range_a: assert property ((!CE_B_O || !OE_B_O || // R2
    !PROGRAM_STROBE_N_O) |-> PROG_ADDR_LINES_O <= LAST_ADDR)
    else $error("address past last cell");
  // Counter already holds the full low time in the cycle the strobe rises
  pulse_width_a: assert property (s_pulse_end |-> // R9
    low_cnt_q == 16'(PULSE_CYC))
    else $error("program pulse length wrong");
  pulse_supply_a: assert property (!PROGRAM_STROBE_N_O |-> // R8
    VPP_HI_O && VDD_HI_O && OE_B_O)
    else $error("pulse without high supplies");
  byte_mode_a: assert property ((!PROGRAM_STROBE_N_O && !CE_B_O) |-> // R10
    PROG_DATA_LINES_OE_O)
    else $error("byte write without data");
  page_mode_a: assert property ((!PROGRAM_STROBE_N_O && CE_B_O) |-> // R9
    !PROG_DATA_LINES_OE_O)
    else $error("page pulse drives data");
  latch_mode_a: assert property ((PROG_DATA_LINES_OE_O && CE_B_O) |-> // R7
    !OE_B_O && PROGRAM_STROBE_N_O)
    else $error("latch strobes wrong");
  no_contend_a: assert property ((!OE_B_O && !CE_B_O) |-> // R5
    !PROG_DATA_LINES_OE_O)
    else $error("driving while device outputs");
  tries_cap_a: assert property (tries_q <= 4'(TRIES)) // R9
    else $error("too many write attempts");
  done_pulse_a: assert property (DONE_O |=> !DONE_O && CMD_READY_O)
    else $error("done not one cycle");

endmodule : ppp_host

`default_nettype wire

/* dv/ppp_prom_model.sv */
// Purpose: Behavioural one-time PROM seen through its programming pins.
// Assumes: Pins settle within 1 ns of the host clock edge.
// Notes:   drop_i makes every program pulse fail, to force verify misses.
`timescale 1ns/1ps
`default_nettype none

module ppp_prom_model
  import ppp_pkg::*;
(
  input  wire logic        rst_b_i,
  input  wire logic        vpp_hi_i,
  input  wire logic        vdd_hi_i,
  input  wire logic        ce_b_i,
  input  wire logic        oe_b_i,
  input  wire logic        program_strobe_n_i,
  input  wire logic        drop_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o
);
  logic [7:0] mem    [0:24575];
  logic [7:0] page_q [0:3];
  logic       prog_hv;

  initial foreach (mem[i]) mem[i] = 8'hff;
  // Programming only in programming mode with both high supplies
  assign prog_hv   = !rst_b_i && vpp_hi_i && vdd_hi_i;
  // Drive only in read and verify; float in disable and standby
  assign data_oe_o = !rst_b_i && !ce_b_i && !oe_b_i &&
                     program_strobe_n_i;
  assign data_o    = mem[addr_i];
  // Page latch; the 1 ns wait lets simultaneous pin changes land first
  always begin
    @(addr_i or data_i or oe_b_i or ce_b_i or program_strobe_n_i);
    #1;
    if (prog_hv && ce_b_i && program_strobe_n_i && !oe_b_i) begin
      page_q[addr_i[1:0]] = data_i;
    end
  end
  // A write needs a program pulse; a high strobe writes nothing
  always @(negedge program_strobe_n_i) begin
    #1;
    if (prog_hv && !drop_i && oe_b_i && ce_b_i) begin
      for (int k = 0; k < 4; k++) mem[{addr_i[14:2], 2'(k)}] = page_q[k];
    end else if (prog_hv && !drop_i && oe_b_i) begin
      mem[addr_i] = data_i;
    end
  end
endmodule : ppp_prom_model

`default_nettype wire

/* dv/test_prom_programming_port.sv */
// Purpose: Self-checking bench for the PROM programming host.
// Assumes: TRIES cut to 3 so the failing write stays short.
// Notes:   Seeded xorshift picks addresses and data.
`timescale 1ns/1ps
`default_nettype none

module test_prom_programming_port
  import ppp_pkg::*;
;
  logic        clk = 0, rst_b = 0, valid = 0, drop = 0;
  ppp_cmd_s    cmd = '0;
  logic        rdy, done, fail, prst_b, vpp, vdd, ce_b, oe_b;
  logic        program_strobe_n;
  logic        h_oe, d_oe;
  logic [7:0]  rdata, h_do, d_do, pin, last = 8'h00;
  logic [14:0] addr;
  logic [14:0] a;
  logic [31:0] d, seed = 32'd27208;
  int          miscompares = 0, num_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;
  // Released bus shows the inverse of its last driven value
  assign pin = h_oe ? h_do : d_oe ? d_do : ~last;
  always @(pin) if (h_oe || d_oe) last = pin;

  ppp_host #(.TRIES(3)) i_ppp_host (.MCLK_I(clk), .RST_B_I(rst_b),
    .CMD_VALID_I(valid), .CMD_I(cmd), .CMD_READY_O(rdy), .DONE_O(done),
    .FAIL_O(fail), .RDATA_O(rdata), .PROM_RST_B_O(prst_b),
    .VPP_HI_O(vpp), .VDD_HI_O(vdd), .CE_B_O(ce_b), .OE_B_O(oe_b),
    .PROGRAM_STROBE_N_O(program_strobe_n), .PROG_ADDR_LINES_O(addr),
    .PROG_DATA_LINES_I(pin), .PROG_DATA_LINES_O(h_do),
    .PROG_DATA_LINES_OE_O(h_oe));
  ppp_prom_model i_ppp_prom_model (.rst_b_i(prst_b), .vpp_hi_i(vpp),
    .vdd_hi_i(vdd), .ce_b_i(ce_b), .oe_b_i(oe_b),
    .program_strobe_n_i(program_strobe_n),
    .drop_i(drop), .addr_i(addr), .data_i(pin), .data_o(d_do),
    .data_oe_o(d_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // One command: request held until taken, then wait for its done pulse
  task automatic run(ppp_op_e op, logic [14:0] ad, logic [31:0] dt,
                     logic ef, logic [7:0] er);
    @(negedge clk);
    valid = 1;
    cmd = '{op, ad, dt};
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    @(negedge clk);
    valid = 0;
    while (done !== 1'b1) @(negedge clk);
    chk("fail_flag", 32'(ef), 32'(fail));
    if (op == PPP_OP_READ && !ef) chk("read_data", 32'(er), 32'(rdata));
    $display("test done op %0d addr %h", op, ad);
  endtask : run

  // Byte write then read back
  task automatic wb(logic [14:0] ad, logic [7:0] dt);
    run(PPP_OP_BYTE, ad, 32'(dt), 0, 8'h00);
    run(PPP_OP_READ, ad, 32'h0, 0, dt);
  endtask : wb

  // Pin monitor: contention, supplies under a pulse, device reset held
  always @(posedge clk) begin
    cyc++;
    if (cyc > 80000) begin
      chk("cycle_limit", 32'h0, 32'h1);
      report_and_stop();
    end
    if (rst_b && h_oe === 1'b1 && d_oe === 1'b1) chk("contention", 0, 1);
    if (rst_b && program_strobe_n === 1'b0)
      chk("pulse_supply", 3, {vpp, vdd});
    if (rst_b && prst_b !== 1'b0) chk("prom_reset", 0, 32'(prst_b));
  end

  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1;
    run(PPP_OP_BYTE, 15'h6000, 32'h5a, 1, 8'h00);
    run(PPP_OP_PAGE, 15'h0002, 32'h0, 1, 8'h00);
    run(ppp_op_e'(2'h3), 15'h0000, 32'h0, 1, 8'h00);
    wb(LAST_ADDR, 8'(rnd()));
    for (int i = 0; i < 4; i++) wb(15'(rnd() % 32'h6000), 8'(rnd()));
    a = 15'(rnd() % 32'h6000) & 15'h7ffc;
    d = rnd();
    run(PPP_OP_PAGE, a, d, 0, 8'h00);
    for (int k = 0; k < 4; k++) run(PPP_OP_READ, a + 15'(k), 0, 0, d[8*k+:8]);
    drop = 1;
    run(PPP_OP_BYTE, a, 32'(~d[7:0]), 1, 8'h00);
    drop = 0;
    run(PPP_OP_READ, a, 32'h0, 0, d[7:0]);
    // Page retry path: every verify misses, so the whole page repeats
    drop = 1;
    run(PPP_OP_PAGE, a, ~d, 1, 8'h00);
    drop = 0;
    run(PPP_OP_READ, a + 15'h3, 32'h0, 0, d[31:24]);
    report_and_stop();
  end
endmodule : test_prom_programming_port

`default_nettype wire
